// ==== ahs_pkg.sv ====
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Shared constants for the axis homing sequencer.
package ahs_pkg;

  // Register bus geometry.
  localparam int unsigned ADR_W  = 8;
  localparam int unsigned DAT_W  = 32;
  localparam int unsigned SEL_W  = DAT_W / 8;

  // Register byte offsets.
  localparam logic [ADR_W-1:0] CTRL_OFS      = 8'h00;
  localparam logic [ADR_W-1:0] MODE_OFS      = 8'h04;
  localparam logic [ADR_W-1:0] START_SPD_OFS = 8'h08;
  localparam logic [ADR_W-1:0] MAX_SPD_OFS   = 8'h0C;
  localparam logic [ADR_W-1:0] ACCEL_OFS     = 8'h10;
  localparam logic [ADR_W-1:0] SKIP_OFS      = 8'h14;
  localparam logic [ADR_W-1:0] STATUS_OFS    = 8'h18;
  localparam logic [ADR_W-1:0] SPEED_OFS     = 8'h1C;
  localparam logic [ADR_W-1:0] IDX_CNT_OFS   = 8'h20;

  // Control register fields (write-one actions, read as zero).
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_ABORT_BIT = 1;

  // Status register fields.
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_DONE_BIT  = 1;
  localparam int unsigned STAT_DIR_BIT   = 2;
  localparam int unsigned STAT_HOME_BIT  = 4;
  localparam int unsigned STAT_LIMIT_BIT = 5;
  localparam int unsigned STAT_INDEX_BIT = 6;

  // Field widths.
  localparam int unsigned MODE_W = 4;
  localparam int unsigned SPD_W  = 16;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned ACC_W  = 24;

  // Reset values of the configuration registers.
  localparam logic [MODE_W-1:0] MODE_RST      = 4'h0;
  localparam logic [SPD_W-1:0]  START_SPD_RST = 16'h0010;
  localparam logic [SPD_W-1:0]  MAX_SPD_RST   = 16'h0100;
  localparam logic [SPD_W-1:0]  ACCEL_RST     = 16'h0001;
  localparam logic [CNT_W-1:0]  SKIP_RST      = 16'h0000;

  // Sensor order inside the sensor vectors.
  localparam int unsigned SENS_N     = 3;
  localparam int unsigned SENS_HOME  = 0;
  localparam int unsigned SENS_LIMIT = 1;
  localparam int unsigned SENS_INDEX = 2;

  // Ramp update interval: a time in ns and its cycle count at 40 MHz.
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned RAMP_TICK_NS  = 1000;
  localparam int unsigned RAMP_TICK_CYC = RAMP_TICK_NS / CLK_PERIOD_NS;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_SEEK,
    ST_CROSS,
    ST_DSTOP,
    ST_DREV,
    ST_IDX,
    ST_OUT,
    ST_CREEP,
    ST_LEAVE
  } ahs_state_e;

endpackage : ahs_pkg

`default_nettype wire

// ==== ahs_sequencer.sv ====
// How it works
// - Sensors active high; rising edge means triggered.
// - Only start and maximum speed, linear ramps.
// - Mode 0 seeks home, decelerates, stops.
// - Mode 1 reverses, re-approaches home edge slowly.
// - Mode 2 decelerates, finds index at start.
// - Skip count sets index pulses ignored.
// - Mode 3 finds index at max, decelerates.
// - Mode 4 reverses at start, then finds index.
// - Mode 5 reverses, accelerates, finds index, decelerates.
// - Mode 6 seeks limit, halts instantly.
// - Mode 7 limit stop, reverse slow, index.
// - Mode 8 limit stop, reverse fast, index.
// - Mode 9 reverses slowly, stops leaving home.
// - Mode 10 index at max, reverse, edge.
// - Mode 11 reverse, fast index, re-approach slowly.
// - Mode 12 limit reverse, fast index, re-approach.
// - Limit first: reverse, cross home, search again.
// - Mode 13 reverses slowly, stops leaving limit.
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module ahs_sequencer
#(
  parameter int unsigned RAMP_CYC = ahs_pkg::RAMP_TICK_CYC
)
(
  input  wire logic                        CLK_I,
  input  wire logic                        RSTN_I,
  input  wire logic                        CYC_I,
  input  wire logic                        STB_I,
  input  wire logic                        WE_I,
  input  wire logic [ahs_pkg::ADR_W-1:0]   ADR_I,
  input  wire logic [ahs_pkg::SEL_W-1:0]   SEL_I,
  input  wire logic [ahs_pkg::DAT_W-1:0]   DAT_I,
  output var  logic [ahs_pkg::DAT_W-1:0]   DAT_O,
  output var  logic                        ACK_O,
  input  wire logic                        HOME_I,
  input  wire logic                        LIMIT_SWITCH_INPUT_I,
  input  wire logic                        ENCODER_INDEX_INPUT_I,
  output var  logic                        STEP_O,
  output var  logic                        DIR_O,
  output var  logic                        BUSY_O,
  output var  logic                        DONE_O
);
  import ahs_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [SENS_N-1:0] sens_raw;
  logic [SENS_N-1:0] sens_meta_ff;
  logic [SENS_N-1:0] sens_sync_ff;
  logic [SENS_N-1:0] sens_prev_ff;
  logic [SENS_N-1:0] sens_rise;
  logic [SENS_N-1:0] sens_fall;

  logic              ack_ff;
  logic [DAT_W-1:0]  rdat_ff;
  logic [MODE_W-1:0] mode_ff;
  logic [SPD_W-1:0]  start_spd_ff;
  logic [SPD_W-1:0]  max_spd_ff;
  logic [SPD_W-1:0]  accel_ff;
  logic [CNT_W-1:0]  skip_ff;

  ahs_state_e        state_ff;
  ahs_state_e        nxt_state;
  logic              dir_ff;
  logic              moving_ff;
  logic              tgt_max_ff;
  logic              late_ff;
  logic              nxt_late;
  logic              seen_ff;
  logic              nxt_seen;
  logic              done_ff;
  logic [CNT_W-1:0]  idx_cnt_ff;
  logic [SPD_W-1:0]  speed_ff;
  logic [ACC_W-1:0]  phase_ff;
  logic              step_ff;
  logic [15:0]       ramp_cnt_ff;

  logic              go;
  logic              halt;
  logic              rev;
  logic              set_max;
  logic              set_start;
  logic              cnt_clr;
  logic              cnt_inc;
  logic              finish;

  //////////////////////////////////////////////////////////////////////////////
  // Sensor synchronisers and edge detectors, one slice per sensor.
  assign sens_raw[SENS_HOME]  = HOME_I;
  assign sens_raw[SENS_LIMIT] = LIMIT_SWITCH_INPUT_I;
  assign sens_raw[SENS_INDEX] = ENCODER_INDEX_INPUT_I;

  genvar gi;
  generate
    for (gi = 0; gi < SENS_N; gi++)
    begin : g_sens
      // Two flops against metastability, a third for edge detection.
      always_ff @(posedge CLK_I)
      begin
        if (!RSTN_I)
        begin
          sens_meta_ff[gi] <= 1'b0;
          sens_sync_ff[gi] <= 1'b0;
          sens_prev_ff[gi] <= 1'b0;
        end
        else
        begin
          sens_meta_ff[gi] <= sens_raw[gi];
          sens_sync_ff[gi] <= sens_meta_ff[gi];
          sens_prev_ff[gi] <= sens_sync_ff[gi];
        end
      end
      // Active-high sensors: a rising edge is a trigger.
      assign sens_rise[gi] = sens_sync_ff[gi] & ~sens_prev_ff[gi];
      assign sens_fall[gi] = ~sens_sync_ff[gi] & sens_prev_ff[gi];
    end
  endgenerate

  // Named sensor events.
  wire home_rise  = sens_rise[SENS_HOME];
  wire home_fall  = sens_fall[SENS_HOME];
  wire lim_rise   = sens_rise[SENS_LIMIT];
  wire lim_fall   = sens_fall[SENS_LIMIT];
  wire idx_rise   = sens_rise[SENS_INDEX];

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone decode; every request is acknowledged one cycle after it is seen.
  wire             req      = CYC_I & STB_I & ~ack_ff;
  wire             wr       = req & WE_I;
  wire             hit_ctrl = (ADR_I == CTRL_OFS);
  wire             hit_mode = (ADR_I == MODE_OFS);
  wire             hit_start_spd = (ADR_I == START_SPD_OFS);
  wire             hit_max_spd   = (ADR_I == MAX_SPD_OFS);
  wire             hit_acc  = (ADR_I == ACCEL_OFS);
  wire             hit_skip = (ADR_I == SKIP_OFS);
  wire             start_cmd = wr & hit_ctrl & SEL_I[0] & DAT_I[CTRL_START_BIT];
  wire             abort_cmd = wr & hit_ctrl & SEL_I[0] & DAT_I[CTRL_ABORT_BIT];
  // Settings are only taken while idle so a run keeps its parameters.
  wire             cfg_wr   = wr & (state_ff == ST_IDLE);

  // Byte-lane merge of write data into an existing 32-bit register view.
  function automatic logic [DAT_W-1:0] merge(input logic [DAT_W-1:0] old_v,
                                             input logic [DAT_W-1:0] new_v,
                                             input logic [SEL_W-1:0] sel);
    logic [DAT_W-1:0] res;
    res = old_v;
    for (int b = 0; b < SEL_W; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Each configuration word after the byte-lane merge; the flops keep the low field.
  wire [DAT_W-1:0] mrg_mode      = merge({{(DAT_W-MODE_W){1'b0}}, mode_ff}, DAT_I, SEL_I);
  wire [DAT_W-1:0] mrg_start_spd = merge({{(DAT_W-SPD_W){1'b0}}, start_spd_ff}, DAT_I, SEL_I);
  wire [DAT_W-1:0] mrg_max_spd   = merge({{(DAT_W-SPD_W){1'b0}}, max_spd_ff}, DAT_I, SEL_I);
  wire [DAT_W-1:0] mrg_accel     = merge({{(DAT_W-SPD_W){1'b0}}, accel_ff}, DAT_I, SEL_I);
  wire [DAT_W-1:0] mrg_skip      = merge({{(DAT_W-CNT_W){1'b0}}, skip_ff}, DAT_I, SEL_I);

  // Status word shows the sequencer's own state and the synced sensors.
  logic [DAT_W-1:0] status_w;
  always_comb
  begin
    status_w                 = '0;
    status_w[STAT_BUSY_BIT]  = (state_ff != ST_IDLE);
    status_w[STAT_DONE_BIT]  = done_ff;
    status_w[STAT_DIR_BIT]   = dir_ff;
    status_w[STAT_HOME_BIT]  = sens_sync_ff[SENS_HOME];
    status_w[STAT_LIMIT_BIT] = sens_sync_ff[SENS_LIMIT];
    status_w[STAT_INDEX_BIT] = sens_sync_ff[SENS_INDEX];
  end

  // Read multiplexer; unmapped offsets and the control word read zero.
  logic [DAT_W-1:0] rd_mux;
  always_comb
  begin
    case (ADR_I)
      MODE_OFS:      rd_mux = {{(DAT_W-MODE_W){1'b0}}, mode_ff};
      START_SPD_OFS: rd_mux = {{(DAT_W-SPD_W){1'b0}}, start_spd_ff};
      MAX_SPD_OFS:   rd_mux = {{(DAT_W-SPD_W){1'b0}}, max_spd_ff};
      ACCEL_OFS:     rd_mux = {{(DAT_W-SPD_W){1'b0}}, accel_ff};
      SKIP_OFS:      rd_mux = {{(DAT_W-CNT_W){1'b0}}, skip_ff};
      STATUS_OFS:    rd_mux = status_w;
      SPEED_OFS:     rd_mux = {{(DAT_W-SPD_W){1'b0}}, speed_ff};
      IDX_CNT_OFS:   rd_mux = {{(DAT_W-CNT_W){1'b0}}, idx_cnt_ff};
      default:       rd_mux = '0;
    endcase
  end

  // Bus answer and configuration registers.
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      ack_ff       <= 1'b0;
      rdat_ff      <= '0;
      mode_ff      <= MODE_RST;
      start_spd_ff <= START_SPD_RST;
      max_spd_ff   <= MAX_SPD_RST;
      accel_ff     <= ACCEL_RST;
      skip_ff      <= SKIP_RST;
    end
    else
    begin
      ack_ff  <= req;
      rdat_ff <= (req & ~WE_I) ? rd_mux : '0;
      if (cfg_wr & hit_mode)
        mode_ff <= mrg_mode[MODE_W-1:0];
      if (cfg_wr & hit_start_spd)
        start_spd_ff <= mrg_start_spd[SPD_W-1:0];
      if (cfg_wr & hit_max_spd)
        max_spd_ff <= mrg_max_spd[SPD_W-1:0];
      if (cfg_wr & hit_acc)
        accel_ff <= mrg_accel[SPD_W-1:0];
      if (cfg_wr & hit_skip)
        skip_ff <= mrg_skip[CNT_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Search target selection: limit-seeking modes versus home-seeking modes.
  wire seek_limit = (mode_ff == 4'h6) | (mode_ff == 4'h7) | (mode_ff == 4'h8) |
                    (mode_ff == 4'hC) | (mode_ff == 4'hD);
  wire trig       = seek_limit ? lim_rise : home_rise;
  wire at_start   = (speed_ff <= start_spd_ff);
  wire idx_hit    = idx_rise & (idx_cnt_ff == skip_ff);

  // Sequencer next-state and action decode.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_late  = late_ff;
    nxt_seen  = seen_ff;
    go        = 1'b0;
    halt      = 1'b0;
    rev       = 1'b0;
    set_max   = 1'b0;
    set_start = 1'b0;
    cnt_clr   = 1'b0;
    cnt_inc   = 1'b0;
    finish    = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (start_cmd)
        begin
          go        = 1'b1;
          set_max   = 1'b1;
          nxt_late  = 1'b0;
          nxt_state = ST_SEEK;
        end
      end
      ST_SEEK:
      begin
        if (!seek_limit && lim_rise)
        begin
          // Limit met before home: turn round and look for a home crossing.
          rev       = 1'b1;
          go        = 1'b1;
          set_start = 1'b1;
          nxt_seen  = 1'b0;
          nxt_state = ST_CROSS;
        end
        else if (trig)
        begin
          case (mode_ff)
            4'h0:
            begin
              set_start = 1'b1;
              nxt_state = ST_DSTOP;
            end
            4'h2:
            begin
              set_start = 1'b1;
              cnt_clr   = 1'b1;
              nxt_state = ST_IDX;
            end
            4'h3, 4'hA:
            begin
              cnt_clr   = 1'b1;
              nxt_state = ST_IDX;
            end
            4'h6:
            begin
              halt      = 1'b1;
              finish    = 1'b1;
              nxt_state = ST_IDLE;
            end
            4'h7:
            begin
              rev       = 1'b1;
              go        = 1'b1;
              set_start = 1'b1;
              cnt_clr   = 1'b1;
              nxt_state = ST_IDX;
            end
            4'h8, 4'hC:
            begin
              rev       = 1'b1;
              go        = 1'b1;
              set_max   = 1'b1;
              cnt_clr   = 1'b1;
              nxt_state = ST_IDX;
            end
            default:
            begin
              set_start = 1'b1;
              nxt_state = ST_DREV;
            end
          endcase
        end
      end
      ST_CROSS:
      begin
        if (home_rise)
          nxt_seen = 1'b1;
        if (seen_ff && home_fall)
        begin
          rev       = 1'b1;
          go        = 1'b1;
          set_max   = 1'b1;
          nxt_state = ST_SEEK;
        end
      end
      ST_DSTOP:
      begin
        if (at_start)
        begin
          halt      = 1'b1;
          finish    = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_DREV:
      begin
        if (at_start)
        begin
          rev = 1'b1;
          if (late_ff)
            nxt_state = ST_CREEP;
          else
          begin
            case (mode_ff)
              4'h1:       nxt_state = ST_OUT;
              4'h9, 4'hD: nxt_state = ST_LEAVE;
              4'h5, 4'hB:
              begin
                set_max   = 1'b1;
                cnt_clr   = 1'b1;
                nxt_state = ST_IDX;
              end
              default:
              begin
                cnt_clr   = 1'b1;
                nxt_state = ST_IDX;
              end
            endcase
          end
        end
      end
      ST_IDX:
      begin
        if (idx_rise && !idx_hit)
          cnt_inc = 1'b1;
        else if (idx_hit)
        begin
          case (mode_ff)
            4'h3, 4'h5, 4'h8:
            begin
              set_start = 1'b1;
              nxt_state = ST_DSTOP;
            end
            4'hA, 4'hB, 4'hC:
            begin
              set_start = 1'b1;
              nxt_late  = 1'b1;
              nxt_state = ST_DREV;
            end
            default:
            begin
              halt      = 1'b1;
              finish    = 1'b1;
              nxt_state = ST_IDLE;
            end
          endcase
        end
      end
      ST_OUT:
      begin
        if (home_fall)
        begin
          rev       = 1'b1;
          nxt_state = ST_CREEP;
        end
      end
      ST_CREEP:
      begin
        if (late_ff ? idx_rise : home_rise)
        begin
          halt      = 1'b1;
          finish    = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_LEAVE:
      begin
        if ((mode_ff == 4'h9) ? home_fall : lim_fall)
        begin
          halt      = 1'b1;
          finish    = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        halt      = 1'b1;
        nxt_state = ST_IDLE;
      end
    endcase
    // Abort overrides the next state, halt and finish, and stops without a ramp.
    if (abort_cmd && state_ff != ST_IDLE)
    begin
      halt      = 1'b1;
      finish    = 1'b0;
      nxt_state = ST_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer state, direction, index counter and completion flag.
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      state_ff   <= ST_IDLE;
      late_ff    <= 1'b0;
      seen_ff    <= 1'b0;
      dir_ff     <= 1'b0;
      tgt_max_ff <= 1'b0;
      idx_cnt_ff <= '0;
      done_ff    <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      late_ff  <= nxt_late;
      seen_ff  <= nxt_seen;
      if (rev)
        dir_ff <= ~dir_ff;
      else if (start_cmd && state_ff == ST_IDLE)
        dir_ff <= 1'b0;
      if (set_max)
        tgt_max_ff <= 1'b1;
      else if (set_start)
        tgt_max_ff <= 1'b0;
      if (cnt_clr)
        idx_cnt_ff <= '0;
      else if (cnt_inc)
        idx_cnt_ff <= idx_cnt_ff + 16'h0001;
      if (finish)
        done_ff <= 1'b1;
      else if (start_cmd)
        done_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Linear ramp between start and maximum speed, updated on a divided tick.
  wire              ramp_tick = (ramp_cnt_ff == 16'(RAMP_CYC - 1));
  wire [SPD_W-1:0]  tgt_spd   = tgt_max_ff ? max_spd_ff : start_spd_ff;
  wire [SPD_W:0]    spd_up    = {1'b0, speed_ff} + {1'b0, accel_ff};
  wire [SPD_W:0]    spd_dn    = {1'b0, speed_ff} - {1'b0, accel_ff};
  wire [SPD_W-1:0]  ramp_up   = (spd_up > {1'b0, tgt_spd}) ? tgt_spd : spd_up[SPD_W-1:0];
  wire [SPD_W-1:0]  ramp_dn   = (spd_dn[SPD_W] || spd_dn[SPD_W-1:0] < tgt_spd) ?
                                tgt_spd : spd_dn[SPD_W-1:0];

  // Speed register and ramp divider.
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      ramp_cnt_ff <= '0;
      speed_ff    <= '0;
      moving_ff   <= 1'b0;
    end
    else
    begin
      ramp_cnt_ff <= ramp_tick ? 16'h0000 : ramp_cnt_ff + 16'h0001;
      if (halt)
      begin
        moving_ff <= 1'b0;
        speed_ff  <= '0;
      end
      else if (go)
      begin
        moving_ff <= 1'b1;
        speed_ff  <= start_spd_ff;
      end
      else if (moving_ff && ramp_tick)
      begin
        if (speed_ff < tgt_spd)
          speed_ff <= ramp_up;
        else if (speed_ff > tgt_spd)
          speed_ff <= ramp_dn;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Step pulse generator: phase accumulator whose carry is one step.
  wire [ACC_W:0] phase_sum = {1'b0, phase_ff} + {{(ACC_W-SPD_W+1){1'b0}}, speed_ff};

  // Registered outputs.
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      phase_ff <= '0;
      step_ff  <= 1'b0;
      STEP_O   <= 1'b0;
      DIR_O    <= 1'b0;
      BUSY_O   <= 1'b0;
      DONE_O   <= 1'b0;
    end
    else
    begin
      phase_ff <= moving_ff ? phase_sum[ACC_W-1:0] : '0;
      step_ff  <= moving_ff & phase_sum[ACC_W];
      STEP_O   <= step_ff;
      DIR_O    <= dir_ff;
      BUSY_O   <= (state_ff != ST_IDLE);
      DONE_O   <= done_ff;
    end
  end

  // Bus outputs straight from flops.
  assign ACK_O = ack_ff;
  assign DAT_O = rdat_ff;

endmodule : ahs_sequencer

`default_nettype wire

// ==== ahs_seq_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none

module ahs_seq_monitor
  import ahs_pkg::*;
(
  input  wire logic                      CLK_I,
  input  wire logic                      RSTN_I,
  input  wire logic                      CYC_I,
  input  wire logic                      STB_I,
  input  wire logic                      WE_I,
  input  wire logic [ahs_pkg::ADR_W-1:0] ADR_I,
  input  wire logic [ahs_pkg::SEL_W-1:0] SEL_I,
  input  wire logic [ahs_pkg::DAT_W-1:0] DAT_I,
  input  wire logic [ahs_pkg::DAT_W-1:0] DAT_O,
  input  wire logic                      ACK_O,
  input  wire logic                      STEP_O,
  input  wire logic                      DIR_O,
  input  wire logic                      BUSY_O,
  input  wire logic                      DONE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  // A taken write of the start bit alone while the axis is idle.
  wire start_req = CYC_I && STB_I && WE_I && !ACK_O && (ADR_I == CTRL_OFS) && SEL_I[0]
                   && DAT_I[CTRL_START_BIT] && !DAT_I[CTRL_ABORT_BIT] && !BUSY_O;

  a_ack_follows: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("ack missing after request");
  a_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (ACK_O |-> $past(CYC_I && STB_I))
    else $error("ack without request");
  a_dat_quiet: assert property (!ACK_O |-> DAT_O == '0)
    else $error("read data outside ack");
  a_start_busy: assert property (start_req |-> ##[1:4] BUSY_O)
    else $error("start did not make the axis busy");
  a_step_pulse: assert property (STEP_O |=> !STEP_O)
    else $error("step pulse too long");
  a_step_in_run: assert property (STEP_O |-> BUSY_O || $past(BUSY_O))
    else $error("step outside a run");
  a_done_idle: assert property (DONE_O |-> !BUSY_O)
    else $error("done while busy");
  a_reset_quiet: assert property ($rose(RSTN_I) |-> !BUSY_O && !DONE_O && !STEP_O)
    else $error("outputs active after reset");

  c_run_done: cover property ($rose(DONE_O));
  c_reversed: cover property ($rose(DIR_O));
  c_busy_bus: cover property (BUSY_O && ACK_O);
endmodule : ahs_seq_monitor

////////////////////////////////////////////////////////////
bind ahs_sequencer ahs_seq_monitor i_mon (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .CYC_I(CYC_I),
  .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
  .ACK_O(ACK_O), .STEP_O(STEP_O), .DIR_O(DIR_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O));

`default_nettype wire

// ==== ahs_axis_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module ahs_axis_model
#(
  parameter int HOME_AT  = 20,
  parameter int HOME_W   = 6,
  parameter int LIMIT_AT = 50,
  parameter int IDX_PER  = 8
)
(
  input  wire logic clk_i,
  input  wire logic step_i,
  input  wire logic dir_i,
  input  wire logic zero_i,
  output var  logic home_o,
  output var  logic limit_o,
  output var  logic index_o,
  output var  int   pos_o
);
  int pos_q = 0;

  // Shaft position moves one count per step, backward when direction is set.
  always @(posedge clk_i)
  begin
    if (zero_i)
      pos_q <= 0;
    else if (step_i)
      pos_q <= dir_i ? pos_q - 1 : pos_q + 1;
  end

  // Sensors are high inside their trigger regions, so a rising edge marks entry.
  assign pos_o   = pos_q;
  assign home_o  = (pos_q >= HOME_AT) && (pos_q < HOME_AT + HOME_W);
  assign limit_o = (pos_q >= LIMIT_AT);
  assign index_o = (pos_q % IDX_PER) == 0;
endmodule : ahs_axis_model

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import ahs_pkg::*;
  localparam int HA = 12;
  localparam int LA = 42;
  localparam int IP = 8;
  logic             clk = 1'b0;
  logic             rstn = 1'b0;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  logic             we = 1'b0;
  logic             zero = 1'b1;
  logic [ADR_W-1:0] adr = '0;
  logic [SEL_W-1:0] sel = '0;
  logic [DAT_W-1:0] wdat = '0;
  logic [DAT_W-1:0] rdat;
  logic [DAT_W-1:0] q;
  logic [DAT_W-1:0] rv;
  logic             ack, step, dir, busy, done, home, limit, index;
  int               pos;
  int               n_mismatch = 0;
  int               check_count = 0;
  // Reset contents expected at each configuration register and the control word, an unmapped one last.
  logic [ADR_W-1:0] ofs[7] = '{MODE_OFS, START_SPD_OFS, MAX_SPD_OFS, ACCEL_OFS, SKIP_OFS,
                               CTRL_OFS, 8'h40};
  logic [DAT_W-1:0] rst_v[7] = '{32'(MODE_RST), 32'(START_SPD_RST), 32'(MAX_SPD_RST),
                                 32'(ACCEL_RST), 32'(SKIP_RST), 32'h0, 32'h0};
  // Expected stop window and direction per mode, with a skip count of one.
  int   md[9] = '{0, 9, 2, 6, 1, 3, 4, 7, 13};
  int   lo[9] = '{HA, HA - 1, (HA / IP + 2) * IP, LA, HA, (HA / IP + 2) * IP,
                  (HA / IP - 1) * IP, (LA / IP - 1) * IP, LA - 1};
  int   hi[9] = '{HA + 2, HA - 1, (HA / IP + 2) * IP, LA, HA, (HA / IP + 2) * IP + 1,
                  (HA / IP - 1) * IP, (LA / IP - 1) * IP, LA - 1};
  logic dr[9] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

  always #12.5 clk = ~clk;

  // Device under test and the axis it drives.
  ahs_sequencer #(.RAMP_CYC(4)) i_dut
  (
    .CLK_I(clk), .RSTN_I(rstn), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .HOME_I(home),
    .LIMIT_SWITCH_INPUT_I(limit), .ENCODER_INDEX_INPUT_I(index), .STEP_O(step),
    .DIR_O(dir), .BUSY_O(busy), .DONE_O(done)
  );
  ahs_axis_model #(.HOME_AT(HA), .LIMIT_AT(LA), .IDX_PER(IP)) i_axis
  (
    .clk_i(clk), .step_i(step), .dir_i(dir), .zero_i(zero), .home_o(home),
    .limit_o(limit), .index_o(index), .pos_o(pos)
  );

  ////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if ((n_mismatch == 0) && (check_count > 0))
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk

  // One classic Wishbone cycle, held until ack is sampled high.
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d,
                    output logic [DAT_W-1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= '1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((ack !== 1'b1) && (n < 100));
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1)
    begin
      n_mismatch++;
      complete_run;
    end
  endtask : wb

  // Waits for busy (which 0) or done (which 1) to reach a level.
  task automatic wait_lvl(input logic which, input logic v);
    int n;
    n = 0;
    while (((which ? done : busy) !== v) && (n < 60000))
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 60000)
    begin
      n_mismatch++;
      complete_run;
    end
  endtask : wait_lvl

  // Puts the axis back at zero, loads the mode and starts a run.
  task automatic start(input int m);
    zero <= 1'b1;
    @(posedge clk);
    zero <= 1'b0;
    wb(1'b1, MODE_OFS, 32'(m), q);
    wb(1'b1, CTRL_OFS, 32'h1, q);
    wait_lvl(1'b0, 1'b1);
  endtask : start

  ////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'had9c));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    zero <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      wb(1'b0, ofs[i], '0, q);
      chk("reset value", rst_v[i], q);
    end
    rv = $urandom;
    wb(1'b1, SKIP_OFS, rv, q);
    wb(1'b0, SKIP_OFS, '0, q);
    chk("skip count", {16'h0, rv[15:0]}, q);
    wb(1'b1, 8'h40, rv, q);
    wb(1'b0, 8'h40, '0, q);
    chk("unmapped", 32'h0, q);
    wb(1'b1, START_SPD_OFS, 32'h8000, q);
    wb(1'b1, MAX_SPD_OFS, 32'hFFFF, q);
    wb(1'b1, ACCEL_OFS, 32'h0800, q);
    wb(1'b1, SKIP_OFS, 32'h1, q);
    start(0);
    wb(1'b1, CTRL_OFS, 32'h2, q);
    wait_lvl(1'b0, 1'b0);
    chk("done after abort", 32'h0, {31'h0, done});
    for (int i = 0; i < 9; i++)
    begin
      start(md[i]);
      if (md[i] == 6)
      begin
        wb(1'b1, MODE_OFS, 32'h5, q);
        wb(1'b0, MODE_OFS, '0, q);
        chk("mode held", 32'h6, q);
        wb(1'b0, SPEED_OFS, '0, q);
        chk("speed range", 32'h1, {31'h0, (q >= 32'h8000) && (q <= 32'hFFFF)});
      end
      wait_lvl(1'b1, 1'b1);
      chk("position", 32'h1, 32'(pos >= lo[i] && pos <= hi[i]));
      chk("direction", {31'h0, dr[i]}, {31'h0, dir});
      chk("busy", 32'h0, {31'h0, busy});
    end
    complete_run;
  end
endmodule : tb_top

`default_nettype wire
